// file: eddc_pkg.sv
// constants, register map and state type of the display-data sink port
// assumes a 125 MHz mclk and a source that masters the two-wire bus
package eddc_pkg;
  localparam int          MCLK_HZ     = 125_000_000;
  localparam int          MCLK_NS     = 8;
  localparam int          HP_LOW_MS   = 100;
  localparam int          HP_LOW_CYC  = HP_LOW_MS * (MCLK_HZ / 1000);
  localparam int          ANSWER_MS   = 20;
  localparam int          STRETCH_NS  = 32;
  localparam int          STRETCH_CYC = (STRETCH_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [6:0]  STORE_ID    = 7'h50;
  localparam logic [6:0]  SEG_ID      = 7'h30;
  localparam int          STORE_BYTES = 32768;
  // register offsets
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_SADDR   = 8'h04;
  localparam logic [7:0]  REG_SDATA   = 8'h08;
  localparam logic [7:0]  REG_PHYS    = 8'h0c;
  localparam logic [7:0]  REG_CAPS    = 8'h10;
  localparam logic [7:0]  REG_CLK     = 8'h14;
  localparam logic [7:0]  REG_LAT     = 8'h18;
  localparam logic [7:0]  REG_VPTR    = 8'h1c;
  localparam logic [7:0]  REG_EXT3    = 8'h20;
  localparam logic [7:0]  REG_COMPOSE = 8'h24;
  localparam logic [7:0]  REG_STATUS  = 8'h28;
  // capability bits
  localparam int          CAP_W       = 9;
  localparam int          CAP_AUX     = 0;
  localparam int          CAP_DC10    = 1;
  localparam int          CAP_DC12    = 2;
  localparam int          CAP_DC16    = 3;
  localparam int          CAP_Y444    = 4;
  localparam int          CAP_DUAL    = 5;
  localparam int          CAP_LAT     = 6;
  localparam int          CAP_ILAT    = 7;
  localparam int          CAP_YCC     = 8;
  // vendor block layout
  localparam logic [2:0]  VCB_TAG     = 3'h3;
  localparam logic [23:0] VCB_OUI     = 24'h5a5a5a; // arbitrary value
  localparam logic [3:0]  VCB_BASE    = 4'h9;
  localparam logic [3:0]  VCB_PAD     = 4'h2;
  localparam logic [7:0]  MIN_CLK     = 8'h21;
  localparam logic [7:0]  LAT_MAX     = 8'hfb;
  localparam logic [7:0]  LAT_NONE    = 8'hff;
  localparam logic [14:0] EXT3_OFS    = 15'h0003;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_RDATA, ST_RACK, ST_WDATA, ST_WACK
  } eddc_state_e;
endpackage

// file: eddc_sink_port.sv
// display-data sink port: store, serial responder, hot plug line
// assumes open-drain pins resolved outside; software owns the store
`timescale 1ns/1ps
module eddc_sink_port #(
  parameter int HP_LOW_CYCLES = eddc_pkg::HP_LOW_CYC
) (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        pwr5v_in,
  output logic             hot_plug_line,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata
);
  import eddc_pkg::*;

  logic [7:0]  mem [0:STORE_BYTES-1];
  logic        scl_s, sda_s, pwr_s;
  logic        scl_q, sda_q;
  logic        scl_rise, scl_fall;
  logic        start, stop;
  eddc_state_e state;
  logic [3:0]  cnt;
  logic [7:0]  sh;
  logic        rw, seg_sel, first, nack;
  logic        sda_oe_reg;
  logic [6:0]  seg_reg;
  logic [7:0]  off_reg;
  logic [7:0]  rd_byte;
  logic        load_now;
  logic [2:0]  stretch_cnt;
  logic        ready_reg;
  logic [14:0] saddr_reg;
  logic [15:0] phys_reg;
  logic [CAP_W-1:0] caps_reg;
  logic [7:0]  clk_reg;
  logic [31:0] lat_reg;
  logic [14:0] vptr_reg;
  logic [7:0]  ext3_reg;
  logic        cmp_busy, cmp_ext;
  logic [3:0]  cmp_idx;
  logic [7:0]  clk_eff;
  logic [CAP_W-1:0] caps_eff;
  logic [7:0]  vbyte;
  logic [3:0]  vlen;
  logic        mem_we;
  logic [14:0] mem_wa;
  logic [7:0]  mem_wd;
  logic        sw_data_wr;
  logic [23:0] hp_timer;

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus events

  eddc_sync u_scl (.mclk(mclk), .sys_rst(sys_rst), .d(scl_in), .q(scl_s));
  eddc_sync u_sda (.mclk(mclk), .sys_rst(sys_rst), .d(sda_in), .q(sda_s));
  eddc_sync u_pwr (.mclk(mclk), .sys_rst(sys_rst), .d(pwr5v_in), .q(pwr_s));

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 1'b0;
      sda_q <= 1'b0;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // bit timing comes only from the source clock edges
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start    = scl_s & scl_q & sda_q & ~sda_s;
  assign stop     = scl_s & scl_q & ~sda_q & sda_s;
  assign load_now = scl_fall & ~start & ~stop &
                    ((state == ST_AACK && rw) || (state == ST_RACK && !nack));

  ////////////////////////////////////////////////////////////////////
  // serial responder

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= ST_IDLE;
      cnt        <= 4'h0;
      sh         <= 8'h00;
      rw         <= 1'b0;
      seg_sel    <= 1'b0;
      nack       <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start) begin
      state      <= ST_ADDR;
      cnt        <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop) begin
      state      <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (load_now) begin
      state      <= ST_RDATA;
      sda_oe_reg <= ~rd_byte[7];
      sh         <= {rd_byte[6:0], 1'b0};
      cnt        <= 4'h1;
    end else begin
      case (state)
        ST_ADDR: begin
          if (scl_rise) begin
            sh  <= {sh[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          if (scl_fall && cnt == 4'h8) begin
            // no wait after power: answers at once when readable
            if (ready_reg && (sh[7:1] == STORE_ID ||
                (sh[7:1] == SEG_ID && !sh[0]))) begin
              state      <= ST_AACK;
              sda_oe_reg <= 1'b1;
              rw         <= sh[0];
              seg_sel    <= (sh[7:1] == SEG_ID);
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            cnt        <= 4'h0;
            state      <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (cnt == 4'h8) begin
              sda_oe_reg <= 1'b0;
              state      <= ST_RACK;
            end else begin
              sda_oe_reg <= ~sh[7];
              sh         <= {sh[6:0], 1'b0};
              cnt        <= cnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) nack <= sda_s;
          if (scl_fall && nack) state <= ST_IDLE;
        end
        ST_WDATA: begin
          if (scl_rise) begin
            sh  <= {sh[6:0], sda_s};
            cnt <= cnt + 4'h1;
          end
          if (scl_fall && cnt == 4'h8) begin
            sda_oe_reg <= 1'b1;
            state      <= ST_WACK;
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            cnt        <= 4'h0;
            state      <= ST_WDATA;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // segment and offset; segment never leaves the chip
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      seg_reg <= 7'h00;
      off_reg <= 8'h00;
      first   <= 1'b0;
    end else if (stop) begin
      seg_reg <= 7'h00;
      first   <= 1'b0;
    end else if (scl_fall && state == ST_AACK) begin
      first <= 1'b1;
    end else if (scl_fall && state == ST_WDATA && cnt == 4'h8) begin
      first <= 1'b0;
      if (seg_sel) seg_reg <= sh[6:0];
      else if (first) off_reg <= sh;
    end else if (scl_fall && state == ST_RDATA && cnt == 4'h8) begin
      off_reg <= off_reg + 8'h01;
    end
  end

  // store read port; address is stable long before the load edge
  always_ff @(posedge mclk) begin
    rd_byte <= mem[{seg_reg, off_reg}];
  end

  // brief hold after the ack lets the first data bit settle on sda before scl rises
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) stretch_cnt <= 3'h0;
    else if (load_now) stretch_cnt <= 3'(STRETCH_CYC);
    else if (stretch_cnt != 3'h0) stretch_cnt <= stretch_cnt - 3'h1;
  end

  assign scl_oe  = (stretch_cnt != 3'h0);
  assign scl_out = 1'b0;
  assign sda_oe  = sda_oe_reg;
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////
  // register port

  assign sw_data_wr = reg_wr && reg_addr == REG_SDATA && !cmp_busy;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_reg <= 1'b0;
      saddr_reg <= 15'h0000;
      phys_reg  <= 16'h0000;
      caps_reg  <= '0;
      clk_reg   <= 8'h00;
      lat_reg   <= 32'h00000000;
      vptr_reg  <= 15'h0000;
      ext3_reg  <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_CTRL:  ready_reg <= reg_wdata[0];
        REG_SADDR: saddr_reg <= reg_wdata[14:0];
        REG_SDATA: if (!cmp_busy) saddr_reg <= saddr_reg + 15'h0001;
        REG_PHYS:  phys_reg  <= reg_wdata[15:0];
        REG_CAPS:  caps_reg  <= reg_wdata[CAP_W-1:0];
        REG_CLK:   clk_reg   <= reg_wdata[7:0];
        REG_LAT:   lat_reg   <= reg_wdata;
        REG_VPTR:  vptr_reg  <= reg_wdata[14:0];
        REG_EXT3:  ext3_reg  <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          REG_CTRL:   reg_rdata <= {31'h0, ready_reg};
          REG_SADDR:  reg_rdata <= {17'h0, saddr_reg};
          REG_SDATA:  reg_rdata <= {24'h0, mem[saddr_reg]};
          REG_PHYS:   reg_rdata <= {16'h0, phys_reg};
          REG_CAPS:   reg_rdata <= {23'h0, caps_reg};
          REG_CLK:    reg_rdata <= {24'h0, clk_reg};
          REG_LAT:    reg_rdata <= lat_reg;
          REG_VPTR:   reg_rdata <= {17'h0, vptr_reg};
          REG_EXT3:   reg_rdata <= {24'h0, ext3_reg};
          REG_STATUS: reg_rdata <= {28'h0, state != ST_IDLE, cmp_busy,
                                    pwr_s, hot_plug_line};
          default:    reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // vendor block compose into the store

  // aux bit goes out straight from the software flag; clock code 0 becomes MIN_CLK when any deep colour or dual bit is set
  always_comb begin
    caps_eff = caps_reg;
    caps_eff[CAP_AUX] = caps_reg[CAP_AUX];
    clk_eff = clk_reg;
    if (clk_reg == 8'h00 && (|caps_reg[CAP_DC16:CAP_DC10] || caps_reg[CAP_DUAL]))
      clk_eff = MIN_CLK;
  end

  eddc_vcb u_vcb (
    .idx      (cmp_idx),
    .phys     (phys_reg),
    .caps     (caps_eff),
    .clk_code (clk_eff),
    .lat      (lat_reg),
    .byte_o   (vbyte),
    .len_o    (vlen)
  );

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_busy <= 1'b0;
      cmp_ext  <= 1'b0;
      cmp_idx  <= 4'h0;
    end else if (!cmp_busy) begin
      cmp_busy <= reg_wr && reg_addr == REG_COMPOSE;
      cmp_ext  <= 1'b0;
      cmp_idx  <= 4'h0;
    end else if (cmp_ext) begin
      cmp_busy <= 1'b0;
      cmp_ext  <= 1'b0;
    end else if (cmp_idx == vlen + VCB_PAD - 4'h1) begin
      cmp_ext <= 1'b1;
    end else begin
      cmp_idx <= cmp_idx + 4'h1;
    end
  end

  always_comb begin
    mem_we = 1'b0;
    mem_wa = saddr_reg;
    mem_wd = reg_wdata[7:0];
    if (cmp_busy) begin
      mem_we = 1'b1;
      if (cmp_ext) begin
        mem_wa = {vptr_reg[14:7], 7'h00} + EXT3_OFS;
        mem_wd = {ext3_reg[7:6], caps_reg[CAP_YCC], caps_reg[CAP_YCC],
                  ext3_reg[3:0]};
      end else begin
        mem_wa = vptr_reg + {11'h000, cmp_idx};
        mem_wd = vbyte;
      end
    end else if (sw_data_wr) begin
      mem_we = 1'b1;
    end
  end

  // full 32K window: base plus 255 extension blocks
  always_ff @(posedge mclk) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
  end

  ////////////////////////////////////////////////////////////////////
  // hot plug line

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) hp_timer <= 24'h000000;
    else if (mem_we) hp_timer <= 24'(HP_LOW_CYCLES - 1);
    else if (hp_timer != 24'h000000) hp_timer <= hp_timer - 24'h000001;
  end

  // low whenever the store could be mid-update or unreadable
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) hot_plug_line <= 1'b0;
    else hot_plug_line <= ready_reg & pwr_s & ~mem_we &
                          (hp_timer == 24'h000000);
  end

  ////////////////////////////////////////////////////////////////////
  // assertions

  property p_hp_gate;
    @(posedge mclk) disable iff (sys_rst)
    hot_plug_line |-> $past(ready_reg) && $past(pwr_s);
  endproperty
  a_hp_gate: assert property (p_hp_gate) else $error("hot plug without store or power");

  property p_hp_drop;
    @(posedge mclk) disable iff (sys_rst)
    mem_we |=> !hot_plug_line ##0 hp_timer == 24'(HP_LOW_CYCLES - 1);
  endproperty
  a_hp_drop: assert property (p_hp_drop) else $error("store change kept hot plug");

  property p_hp_hold;
    @(posedge mclk) disable iff (sys_rst)
    hp_timer != 24'h000000 |=> !hot_plug_line;
  endproperty
  a_hp_hold: assert property (p_hp_hold) else $error("hot plug rose early");

  property p_seg_clear;
    @(posedge mclk) disable iff (sys_rst)
    stop |=> seg_reg == 7'h00 && state == ST_IDLE;
  endproperty
  a_seg_clear: assert property (p_seg_clear) else $error("segment kept after stop");

  property p_off_inc;
    @(posedge mclk) disable iff (sys_rst)
    (scl_fall && state == ST_RDATA && cnt == 4'h8 && !start && !stop)
      |=> off_reg == $past(off_reg) + 8'h01 ##0 state == ST_RACK;
  endproperty
  a_off_inc: assert property (p_off_inc) else $error("offset not advanced");

  property p_stretch;
    @(posedge mclk) disable iff (sys_rst)
    $rose(scl_oe) |-> scl_oe[*4] ##1 !scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("clock hold length wrong");

  property p_stretch_src;
    @(posedge mclk) disable iff (sys_rst)
    $rose(scl_oe) |-> state == ST_RDATA && cnt == 4'h1;
  endproperty
  a_stretch_src: assert property (p_stretch_src) else $error("clock held outside ack");

  property p_clk_code;
    @(posedge mclk) disable iff (sys_rst)
    (caps_reg[CAP_DUAL] || |caps_reg[CAP_DC16:CAP_DC10]) |-> clk_eff != 8'h00;
  endproperty
  a_clk_code: assert property (p_clk_code) else $error("link clock code zero");

  property p_pad_zero;
    @(posedge mclk) disable iff (sys_rst)
    cmp_busy && !cmp_ext && cmp_idx >= vlen |-> mem_wd == 8'h00;
  endproperty
  a_pad_zero: assert property (p_pad_zero) else $error("trailing byte not zero");

  property p_ycc;
    @(posedge mclk) disable iff (sys_rst)
    cmp_ext |-> mem_wd[5] == mem_wd[4] && mem_wd[4] == caps_reg[CAP_YCC];
  endproperty
  a_ycc: assert property (p_ycc) else $error("ycc bits differ");

  c_read:    cover property (@(posedge mclk) disable iff (sys_rst) load_now);
  c_segment: cover property (@(posedge mclk) disable iff (sys_rst) seg_reg != 7'h00);
  c_compose: cover property (@(posedge mclk) disable iff (sys_rst) cmp_ext);
  c_hp:      cover property (@(posedge mclk) disable iff (sys_rst) $rose(hot_plug_line));
endmodule

// file: eddc_sink_port_bench.sv
// self-checking bench for the display-data sink port
// assumes eddc_src_model as the source and pull-ups on both wires
`timescale 1ns/1ps
module eddc_sink_port_bench;
  import eddc_pkg::*;
  // short hot plug low time keeps the run small
  localparam int HP_LOW = 20;
  logic        mclk = 1'b0, sys_rst = 1'b1, pwr5v_in = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, q, b, m [4];
  logic [31:0] reg_wdata = 32'h0, reg_rdata, lat, rv;
  logic        scl_oe, sda_oe, hot_plug_line, m_scl_low, m_sda_low, ack;
  logic [15:0] phys;
  wire         scl_w = !(m_scl_low || scl_oe);
  wire         sda_w = !(m_sda_low || sda_oe);
  int          fail_count = 0, checks_done = 0;
  eddc_sink_port #(.HP_LOW_CYCLES(HP_LOW)) DUT (
    .mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_w), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda_w), .sda_out(), .sda_oe(sda_oe), .pwr5v_in(pwr5v_in),
    .hot_plug_line(hot_plug_line), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  eddc_src_model SRC (.scl(scl_w), .sda(sda_w), .scl_low(m_scl_low), .sda_low(m_sda_low));
  always #4 mclk = ~mclk;
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %0h exp %0h", $time, w, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic peek(input logic [14:0] a, output logic [7:0] v);
    wr(REG_SADDR, {17'h0, a});
    rd(REG_SDATA, rv);
    v = rv[7:0];
  endtask
  task automatic hp(input logic e, input int n);
    repeat (n) @(posedge mclk);
    #1 chk(hot_plug_line, e, "hot plug");
  endtask
  task automatic sx(input logic [7:0] d, input logic last);
    SRC.xfer(d, last, q, ack);
  endtask
  function automatic logic [7:0] lc(input int ms);
    return 8'(ms / 2 + 1);
  endfunction
  // clock code 0 must come out as the 165 MHz floor in both setups
  task automatic vcb_chk(input logic [8:0] c, input logic [7:0] e6, e8, ex);
    logic [7:0] e [4:14];
    int last;
    e = '{phys[15:8], phys[7:0], e6, 8'h21, e8, lat[7:0], lat[15:8], lat[23:16],
          lat[31:24], 8'h00, 8'h00};
    last = c[CAP_LAT] ? (c[CAP_ILAT] ? 12 : 10) : 8;
    wr(REG_CAPS, {23'h0, c});
    wr(REG_COMPOSE, 32'h1);
    hp(1'b0, 30);
    peek(15'h84, b);
    chk(b, {VCB_TAG, 1'b0, 4'(last)}, "vcb header");
    for (int i = 1; i <= 3; i++) begin
      peek(15'h84 + 15'(i), b);
      chk(b, 8'(VCB_OUI >> (8 * (i - 1))), "vcb id");
    end
    for (int i = 4; i <= last + 2; i++) begin
      peek(15'h84 + 15'(i), b);
      if (i <= 8) chk(b, e[i], "vcb head");
      else chk(b, (i > last) ? 8'h00 : e[i], "vcb tail");
    end
    peek(15'h83, b);
    chk(b, ex, "ext byte 3");
    $display("test compose %0h done", c);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(77));
    foreach (m[i]) m[i] = 8'($urandom);
    phys = 16'($urandom);
    lat = {LAT_NONE, lc($urandom_range(0, 500)), lc($urandom_range(0, 500)), lc(500)};
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    wr(REG_CTRL, 32'h1);
    hp(1'b0, HP_LOW + 8);
    @(posedge mclk);
    pwr5v_in <= 1'b1;
    hp(1'b1, HP_LOW + 8);
    // top segment, wrap point and base byte
    wr(REG_SADDR, 32'h7ffe);
    wr(REG_SDATA, {24'h0, m[0]});
    wr(REG_SDATA, {24'h0, m[1]});
    wr(REG_SADDR, 32'h7f00);
    wr(REG_SDATA, {24'h0, m[2]});
    wr(REG_SADDR, 32'h0);
    wr(REG_SDATA, {24'h0, m[3]});
    hp(1'b0, HP_LOW - 2);
    hp(1'b1, 8);
    rd(REG_STATUS, rv);
    chk(rv, 32'h3, "status idle");
    rd(8'hfc, rv);
    chk(rv, 0, "unmapped read");
    $display("test register side done");
    SRC.start();
    sx(8'h60, 1'b1);
    chk(ack, 1, "segment ack");
    sx(8'h7f, 1'b1);
    SRC.start();
    sx(8'ha0, 1'b1);
    sx(8'hfe, 1'b1);
    chk(ack, 1, "offset ack");
    SRC.start();
    sx(8'ha1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      sx(8'hff, i == 2);
      chk(q, m[i], "segment read");
    end
    SRC.stop();
    SRC.start();
    sx(8'h61, 1'b1);
    chk(ack, 0, "segment not readable");
    SRC.stop();
    SRC.start();
    sx(8'ha0, 1'b1);
    sx(8'h00, 1'b1);
    SRC.start();
    sx(8'ha1, 1'b1);
    sx(8'hff, 1'b1);
    chk(q, m[3], "segment cleared");
    SRC.stop();
    $display("test serial side done");
    wr(REG_PHYS, {16'h0, phys});
    wr(REG_CLK, 32'h0);
    wr(REG_LAT, lat);
    wr(REG_VPTR, 32'h84);
    wr(REG_EXT3, 32'h0);
    vcb_chk(9'h1db, 8'hd8, 8'hc0, 8'h30);
    vcb_chk(9'h030, 8'h01, 8'h00, 8'h00);
    test_done();
  end
  initial begin
    #200_000;
    fail_count++;
    test_done();
  end
endmodule

// file: eddc_src_model.sv
// source-side two-wire master model, bit-banged on its own delays
// assumes the bench resolves both open-drain wires with pull-ups
`timescale 1ns/1ps
module eddc_src_model (
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  // half bit of the 160 ns link clock; sink samples it with mclk
  localparam int HALF = 80;
  initial {scl_low, sda_low} = 2'b00;
  ////////////////////////////////////////
  // release scl, then stall while the sink stretches it
  task automatic rise;
    scl_low = 1'b0;
    for (int n = 0; n < 999 && !scl; n++) #8;
    #HALF;
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_low = !b;
    #HALF;
    rise();
    r = sda;
    scl_low = 1'b1;
  endtask
  // also serves as repeated start
  task automatic start;
    sda_low = 1'b0;
    #HALF;
    rise();
    sda_low = 1'b1;
    #HALF;
    scl_low = 1'b1;
  endtask
  task automatic stop;
    sda_low = 1'b1;
    #HALF;
    rise();
    sda_low = 1'b0;
    #HALF;
  endtask
  // last=1 leaves the ack slot released: write, or nack ending a read
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(last, r);
    ack = !r;
  endtask
endmodule

// file: eddc_sync.sv
// two-flop synchroniser for one pin
// assumes the pin is asynchronous to mclk
`timescale 1ns/1ps
module eddc_sync (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic d,
  output logic      q
);
  logic meta_reg;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_reg <= 1'b0;
      q        <= 1'b0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// file: eddc_vendor_capability_block.sv
// vendor capability block byte generator, indexed by byte position
// assumes fields are stable while a compose runs
`timescale 1ns/1ps
module eddc_vcb
  import eddc_pkg::*;
(
  input  wire logic [3:0]                idx,
  input  wire logic [15:0]               phys,
  input  wire logic [eddc_pkg::CAP_W-1:0] caps,
  input  wire logic [7:0]                clk_code,
  input  wire logic [31:0]               lat,
  output logic      [7:0]                byte_o,
  output logic      [3:0]                len_o
);
  logic lat_on;
  logic ilat_on;
  logic any_dc;

  function automatic logic [7:0] lat_fix(input logic [7:0] c);
    // codes between max and none mean nothing; send unknown
    lat_fix = (c > LAT_MAX && c != LAT_NONE) ? 8'h00 : c;
  endfunction

  always_comb begin
    lat_on  = caps[CAP_LAT];
    ilat_on = lat_on & caps[CAP_ILAT];
    any_dc  = |caps[CAP_DC16:CAP_DC10];
    len_o   = VCB_BASE;
    if (lat_on) len_o = len_o + 4'h2;
    if (ilat_on) len_o = len_o + 4'h2;
    case (idx)
      4'h0: byte_o = {VCB_TAG, 1'b0, len_o - 4'h1};
      4'h1: byte_o = VCB_OUI[7:0];
      4'h2: byte_o = VCB_OUI[15:8];
      4'h3: byte_o = VCB_OUI[23:16];
      4'h4: byte_o = phys[15:8];
      4'h5: byte_o = phys[7:0];
      4'h6: byte_o = {caps[CAP_AUX], caps[CAP_DC16], caps[CAP_DC12],
                      caps[CAP_DC10], caps[CAP_Y444] & any_dc,
                      2'b00, caps[CAP_DUAL]};
      4'h7: byte_o = clk_code;
      4'h8: byte_o = {lat_on, ilat_on, 6'h00};
      4'h9: byte_o = lat_fix(lat[7:0]);
      4'ha: byte_o = lat_fix(lat[15:8]);
      4'hb: byte_o = lat_fix(lat[23:16]);
      4'hc: byte_o = lat_fix(lat[31:24]);
      default: byte_o = 8'h00;
    endcase
    if (idx >= len_o) byte_o = 8'h00;
  end
endmodule
